/* logic/general_timer_regs.svh */
// Purpose: Register addresses, field positions, reset values and divider counts of the timer group.
// Assumes: 8-bit special function register port, 200 MHz system clock.
// Notes:   Definitions only.
`ifndef GENERAL_TIMER_REGS_SVH
`define GENERAL_TIMER_REGS_SVH

// ==========================================================================
// Register addresses
`define TIMER_CONTROL_ADDR        8'h88
`define CLASSIC_TIMER_MODE_ADDR   8'h89
`define FIRST_TIMER_LOW_ADDR      8'h8A
`define SECOND_TIMER_LOW_ADDR     8'h8B
`define FIRST_TIMER_HIGH_ADDR     8'h8C
`define SECOND_TIMER_HIGH_ADDR    8'h8D
`define TIMER_CLOCK_CONTROL_ADDR  8'h8E
`define THIRD_TIMER_CONTROL_ADDR  8'hC8
`define THIRD_RELOAD_LOW_ADDR     8'hCA
`define THIRD_RELOAD_HIGH_ADDR    8'hCB
`define THIRD_COUNT_LOW_ADDR      8'hCC
`define THIRD_COUNT_HIGH_ADDR     8'hCD

// ==========================================================================
// Timer control bits
`define TCTL_SECOND_FLAG  7
`define TCTL_SECOND_RUN   6
`define TCTL_FIRST_FLAG   5
`define TCTL_FIRST_RUN    4

// ==========================================================================
// Mode register fields
`define MODE_SECOND_GATE  7
`define MODE_SECOND_CT    6
`define MODE_SECOND_HI    5
`define MODE_SECOND_LO    4
`define MODE_FIRST_GATE   3
`define MODE_FIRST_CT     2
`define MODE_FIRST_HI     1
`define MODE_FIRST_LO     0

// ==========================================================================
// Clock control fields
`define CKC_RSVD_HI       7
`define CKC_RSVD_LO       6
`define CKC_THIRD_HIGH    5
`define CKC_THIRD_LOW     4
`define CKC_SECOND_CLK    3
`define CKC_FIRST_CLK     2
`define CKC_PRESCALE_HI   1
`define CKC_PRESCALE_LO   0
`define CKC_WRITE_MASK    8'h3F

// ==========================================================================
// Third timer control fields
`define T3C_HIGH_FLAG     7
`define T3C_LOW_FLAG      6
`define T3C_LOW_IRQ_EN    5
`define T3C_CAPTURE_EN    4
`define T3C_SPLIT         3
`define T3C_RUN           2
`define T3C_EXT_SEL       0

// ==========================================================================
// Reset values and dividers
`define REG_RESET         8'h00
`define DIV4_LAST         6'h03
`define DIV12_LAST        6'h0B
`define DIV48_LAST        6'h2F
`define BYTE_ALL_ONES     8'hFF

`endif

/* logic/general_timer_pkg.sv */
// Purpose: Types shared by the timer group.
// Assumes: Nothing beyond the register header.
// Notes:   Mode order follows the two-bit mode field encoding.
package general_timer_pkg;

    typedef enum logic [1:0] {
        MODE_13BIT,
        MODE_16BIT,
        MODE_8BIT_RELOAD,
        MODE_SPLIT
    } classic_mode_e;

endpackage

/* logic/sync_fall_detect.sv */
// Purpose: Synchronise one input to the system clock and pulse on each falling edge.
// Assumes: Input may change at any time.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/1ps

module sync_fall_detect
(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic din,
    output logic      fall
);

    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            meta_q <= din;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign fall = prev_q & ~sync_q;

endmodule

/* logic/general_timer_group.sv */
// Purpose: Two classic counter/timers and one 16-bit auto-reload/capture timer.
// Assumes: Register port is synchronous to clk; one access per cycle.
// Notes:   Read data is registered one cycle after the read strobe.
//
// Behaviour
// - Gate bit 0: run bit alone enables; gate 1: also needs gate input active.
// - Counter-select 0 counts internal clock; 1 counts count pin falling edges, except second timer while first is split.
// - First timer mode field: 13-bit, 16-bit, 8-bit reload, two 8-bit counters.
// - Second timer mode field: 13-bit, 16-bit, 8-bit reload, inactive.
// - Clock-select picks prescaled or system clock; ignored when counting pins.
// - Prescale field: divide by 12, 4, 48, or external clock divided by 8.
// - External divided clock is synchronised before any timer uses it.
// - Third timer high clock-select acts only in split mode.
// - Third timer low clock-select clocks whole timer, or low byte when split.
// - Top two clock control bits read zero; software writes zeros.
// - 16-bit wrap from all ones reloads counter and sets high flag.
// - Interrupt on full overflow; also on low wrap when low enable set.
// - Split mode: two 8-bit reload timers using their own reload bytes.
// - Split mode: run bit gates only high byte; low byte always counts.
// - Byte clock: system clock, else divide by 12 or external divide by 8.
// - Split wraps set high or low flag; low interrupts only when enabled.
// - Third timer flags are cleared only by software.
// - Capture copies 16-bit count into reload bytes and sets high flag.
// - Capture event on each falling edge of external divided clock.
// - Capture mode: low byte, or whole timer unless split, counts system clock or its divide by 12.
// - 8-bit reload mode: low wrap sets flag and reloads from high byte.
// - 13-bit mode uses high byte and five low bits; flag on wrap.
// - Dual 8-bit mode: high byte uses second run bit, second flag.
// - Capture-enable bit switches capture mode off or on.
`timescale 1ns/1ps
`include "general_timer_regs.svh"

module general_timer_group
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic       gate_input,
    input  wire logic       first_gate_polarity,
    input  wire logic       second_gate_polarity,
    input  wire logic       first_count_pin,
    input  wire logic       second_count_pin,
    input  wire logic       ext_clk_div8,
    output logic            first_timer_overflow_flag,
    output logic            second_timer_overflow_flag,
    output logic            third_timer_irq
);

    // ======================================================================
    // Helpers
    function automatic logic wr_hit(input logic [7:0] a);
        return sfr_wr && (sfr_addr == a);
    endfunction

    // Returns {overflow, high, low} after one count in the given mode.
    function automatic logic [16:0] classic_step(input general_timer_pkg::classic_mode_e m,
                                                 input logic [7:0] lo, input logic [7:0] hi);
        logic [13:0] c13;
        logic [16:0] c16;
        logic [8:0]  c8;
        c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        c16 = {1'b0, hi, lo} + 17'h00001;
        c8  = {1'b0, lo} + 9'h001;
        unique case (m)
            general_timer_pkg::MODE_13BIT:       return {c13[13], c13[12:5], lo[7:5], c13[4:0]};
            general_timer_pkg::MODE_16BIT:       return c16;
            general_timer_pkg::MODE_8BIT_RELOAD: return {c8[8], hi, c8[8] ? hi : c8[7:0]};
            general_timer_pkg::MODE_SPLIT:       return {c8[8], hi, c8[7:0]};
        endcase
    endfunction

    // ======================================================================
    // Registers
    logic [7:0] mode_q;
    logic [7:0] timer_clock_control_q;
    logic       run0_q;
    logic       run1_q;
    logic       tf0_q;
    logic       tf1_q;
    logic [7:0] tl0_q;
    logic [7:0] th0_q;
    logic [7:0] tl1_q;
    logic [7:0] th1_q;
    logic       third_timer_high_overflow_flag_q;
    logic       third_timer_low_overflow_flag_q;
    logic       len_q;
    logic       cen_q;
    logic       split_q;
    logic       run2_q;
    logic       xclk_q;
    logic [7:0] rll_q;
    logic [7:0] rlh_q;
    logic [7:0] t2l_q;
    logic [7:0] t2h_q;
    logic [7:0] rdata_q;

    // ======================================================================
    // Input edges and prescaler
    logic       t0_fall;
    logic       t1_fall;
    logic       ext_fall;
    logic [1:0] div4_q;
    logic [3:0] div12_q;
    logic [5:0] div48_q;
    logic       tick4;
    logic       tick12;
    logic       tick48;
    logic       presc_tick;

    // Pins are re-synchronised even though nominally synchronous, so a slow edge counts once.
    sync_fall_detect u_t0_edge (.clk(clk), .srst(srst), .din(first_count_pin), .fall(t0_fall));
    sync_fall_detect u_t1_edge (.clk(clk), .srst(srst), .din(second_count_pin), .fall(t1_fall));
    sync_fall_detect u_ext_edge (.clk(clk), .srst(srst), .din(ext_clk_div8), .fall(ext_fall));

    assign tick4  = ({4'h0, div4_q} == `DIV4_LAST);
    assign tick12 = ({2'h0, div12_q} == `DIV12_LAST);
    assign tick48 = (div48_q == `DIV48_LAST);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            div4_q  <= 2'h0;
            div12_q <= 4'h0;
            div48_q <= 6'h00;
        end
        else
        begin
            div4_q  <= div4_q + 2'h1;
            div12_q <= tick12 ? 4'h0 : div12_q + 4'h1;
            div48_q <= tick48 ? 6'h00 : div48_q + 6'h01;
        end
    end

    always_comb
    begin
        unique case (timer_clock_control_q[`CKC_PRESCALE_HI:`CKC_PRESCALE_LO])
            2'b00: presc_tick = tick12;
            2'b01: presc_tick = tick4;
            2'b10: presc_tick = tick48;
            2'b11: presc_tick = ext_fall;
        endcase
    end

    // ======================================================================
    // Classic timers
    general_timer_pkg::classic_mode_e m0;
    general_timer_pkg::classic_mode_e m1;
    logic        en0;
    logic        en1;
    logic        gate_input_tick;
    logic        int1_tick;
    logic        tick0;
    logic        tick1;
    logic        th0_tick;
    logic        t0_split;
    logic [16:0] nx0;
    logic [16:0] nx1;
    logic [8:0]  th0_inc;
    logic        ovf0;
    logic        ovf1;
    logic        ovf_th0;

    assign m0        = general_timer_pkg::classic_mode_e'(mode_q[`MODE_FIRST_HI:`MODE_FIRST_LO]);
    assign m1        = general_timer_pkg::classic_mode_e'(mode_q[`MODE_SECOND_HI:`MODE_SECOND_LO]);
    assign t0_split  = (m0 == general_timer_pkg::MODE_SPLIT);
    assign en0 = run0_q & (~mode_q[`MODE_FIRST_GATE] | (gate_input == first_gate_polarity));
    assign gate_input_tick = timer_clock_control_q[`CKC_FIRST_CLK] | presc_tick;
    assign int1_tick = timer_clock_control_q[`CKC_SECOND_CLK] | presc_tick;
    assign tick0     = mode_q[`MODE_FIRST_CT] ? t0_fall : gate_input_tick;
    // While the first timer is split, the second cannot count pins and its run bit is lent away.
    assign tick1     = (mode_q[`MODE_SECOND_CT] && !t0_split) ? t1_fall : int1_tick;
    assign en1 = (t0_split | run1_q) & (~mode_q[`MODE_SECOND_GATE] | (gate_input == second_gate_polarity))
                 & (m1 != general_timer_pkg::MODE_SPLIT);
    assign th0_tick  = t0_split & run1_q & gate_input_tick;
    assign nx0       = classic_step(m0, tl0_q, th0_q);
    assign nx1       = classic_step(m1, tl1_q, th1_q);
    assign th0_inc   = {1'b0, th0_q} + 9'h001;
    assign ovf0      = en0 & tick0 & nx0[16];
    assign ovf1      = en1 & tick1 & nx1[16] & ~t0_split;
    assign ovf_th0   = th0_tick & th0_inc[8];

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            tl0_q <= `REG_RESET;
            th0_q <= `REG_RESET;
        end
        else
        begin
            if (wr_hit(`FIRST_TIMER_LOW_ADDR))
                tl0_q <= sfr_wdata;
            else if (en0 && tick0)
                tl0_q <= nx0[7:0];
            if (wr_hit(`FIRST_TIMER_HIGH_ADDR))
                th0_q <= sfr_wdata;
            else if (th0_tick)
                th0_q <= th0_inc[7:0];
            else if (en0 && tick0 && !t0_split)
                th0_q <= nx0[15:8];
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            tl1_q <= `REG_RESET;
            th1_q <= `REG_RESET;
        end
        else
        begin
            if (wr_hit(`SECOND_TIMER_LOW_ADDR))
                tl1_q <= sfr_wdata;
            else if (en1 && tick1)
                tl1_q <= nx1[7:0];
            if (wr_hit(`SECOND_TIMER_HIGH_ADDR))
                th1_q <= sfr_wdata;
            else if (en1 && tick1)
                th1_q <= nx1[15:8];
        end
    end

    // Hardware set wins over a software clear in the same cycle.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            run0_q <= 1'b0;
            run1_q <= 1'b0;
            tf0_q  <= 1'b0;
            tf1_q  <= 1'b0;
        end
        else
        begin
            if (wr_hit(`TIMER_CONTROL_ADDR))
            begin
                run0_q <= sfr_wdata[`TCTL_FIRST_RUN];
                run1_q <= sfr_wdata[`TCTL_SECOND_RUN];
            end
            tf0_q <= (wr_hit(`TIMER_CONTROL_ADDR) ? sfr_wdata[`TCTL_FIRST_FLAG] : tf0_q) | ovf0;
            tf1_q <= (wr_hit(`TIMER_CONTROL_ADDR) ? sfr_wdata[`TCTL_SECOND_FLAG] : tf1_q)
                     | ovf1 | ovf_th0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mode_q  <= `REG_RESET;
            timer_clock_control_q <= `REG_RESET;
        end
        else
        begin
            if (wr_hit(`CLASSIC_TIMER_MODE_ADDR))
                mode_q <= sfr_wdata;
            if (wr_hit(`TIMER_CLOCK_CONTROL_ADDR))
                timer_clock_control_q <= sfr_wdata & `CKC_WRITE_MASK;
        end
    end

    // ======================================================================
    // Third timer
    logic        ext_or_12;
    logic        tick2l;
    logic        tick2h;
    logic        run2l;
    logic        run2h;
    logic [16:0] t2_inc16;
    logic [8:0]  t2l_inc;
    logic [8:0]  t2h_inc;
    logic        wrap16;
    logic        wrap_l;
    logic        wrap_h;
    logic        capture;

    assign ext_or_12 = xclk_q ? ext_fall : tick12;
    // Capture mode measures the external clock, so the low byte (whole timer unless split) cannot also count it.
    assign tick2l  = timer_clock_control_q[`CKC_THIRD_LOW] | (cen_q ? tick12 : ext_or_12);
    assign tick2h  = split_q ? (timer_clock_control_q[`CKC_THIRD_HIGH] | ext_or_12) : tick2l;
    assign run2l   = (split_q | run2_q) & tick2l;
    assign run2h   = run2_q & tick2h;
    assign t2_inc16 = {1'b0, t2h_q, t2l_q} + 17'h00001;
    assign t2l_inc = {1'b0, t2l_q} + 9'h001;
    assign t2h_inc = {1'b0, t2h_q} + 9'h001;
    assign wrap16  = !split_q && run2l && t2_inc16[16];
    assign wrap_l  = run2l && t2l_inc[8];
    assign wrap_h  = split_q && run2h && t2h_inc[8];
    assign capture = cen_q & ext_fall;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            t2l_q <= `REG_RESET;
            t2h_q <= `REG_RESET;
        end
        else
        begin
            if (wr_hit(`THIRD_COUNT_LOW_ADDR))
                t2l_q <= sfr_wdata;
            else if (wrap16 || (split_q && wrap_l))
                t2l_q <= rll_q;
            else if (run2l)
                t2l_q <= t2l_inc[7:0];
            if (wr_hit(`THIRD_COUNT_HIGH_ADDR))
                t2h_q <= sfr_wdata;
            else if (wrap16 || wrap_h)
                t2h_q <= rlh_q;
            else if (split_q ? run2h : run2l)
                t2h_q <= split_q ? t2h_inc[7:0] : t2_inc16[15:8];
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rll_q <= `REG_RESET;
            rlh_q <= `REG_RESET;
        end
        else if (capture)
        begin
            rll_q <= t2l_q;
            rlh_q <= t2h_q;
        end
        else
        begin
            if (wr_hit(`THIRD_RELOAD_LOW_ADDR))
                rll_q <= sfr_wdata;
            if (wr_hit(`THIRD_RELOAD_HIGH_ADDR))
                rlh_q <= sfr_wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            third_timer_high_overflow_flag_q  <= 1'b0;
            third_timer_low_overflow_flag_q  <= 1'b0;
            len_q   <= 1'b0;
            cen_q   <= 1'b0;
            split_q <= 1'b0;
            run2_q  <= 1'b0;
            xclk_q  <= 1'b0;
        end
        else
        begin
            if (wr_hit(`THIRD_TIMER_CONTROL_ADDR))
            begin
                len_q   <= sfr_wdata[`T3C_LOW_IRQ_EN];
                cen_q   <= sfr_wdata[`T3C_CAPTURE_EN];
                split_q <= sfr_wdata[`T3C_SPLIT];
                run2_q  <= sfr_wdata[`T3C_RUN];
                xclk_q  <= sfr_wdata[`T3C_EXT_SEL];
            end
            third_timer_high_overflow_flag_q <= (wr_hit(`THIRD_TIMER_CONTROL_ADDR) ? sfr_wdata[`T3C_HIGH_FLAG] : third_timer_high_overflow_flag_q)
                      | wrap16 | wrap_h | capture;
            third_timer_low_overflow_flag_q <= (wr_hit(`THIRD_TIMER_CONTROL_ADDR) ? sfr_wdata[`T3C_LOW_FLAG] : third_timer_low_overflow_flag_q)
                      | wrap_l;
        end
    end

    assign third_timer_irq = third_timer_high_overflow_flag_q | (third_timer_low_overflow_flag_q & len_q);
    assign first_timer_overflow_flag  = tf0_q;
    assign second_timer_overflow_flag = tf1_q;

    // ======================================================================
    // Read port
    always_ff @(posedge clk)
    begin
        if (srst)
            rdata_q <= `REG_RESET;
        else if (sfr_rd)
        begin
            case (sfr_addr)
                `TIMER_CONTROL_ADDR:       rdata_q <= {tf1_q, run1_q, tf0_q, run0_q, 4'h0};
                `CLASSIC_TIMER_MODE_ADDR:  rdata_q <= mode_q;
                `FIRST_TIMER_LOW_ADDR:     rdata_q <= tl0_q;
                `SECOND_TIMER_LOW_ADDR:    rdata_q <= tl1_q;
                `FIRST_TIMER_HIGH_ADDR:    rdata_q <= th0_q;
                `SECOND_TIMER_HIGH_ADDR:   rdata_q <= th1_q;
                `TIMER_CLOCK_CONTROL_ADDR: rdata_q <= {2'b00, timer_clock_control_q[5:0]};
                `THIRD_TIMER_CONTROL_ADDR: rdata_q <= {third_timer_high_overflow_flag_q, third_timer_low_overflow_flag_q, len_q, cen_q, split_q, run2_q, 1'b0, xclk_q};
                `THIRD_RELOAD_LOW_ADDR:    rdata_q <= rll_q;
                `THIRD_RELOAD_HIGH_ADDR:   rdata_q <= rlh_q;
                `THIRD_COUNT_LOW_ADDR:     rdata_q <= t2l_q;
                `THIRD_COUNT_HIGH_ADDR:    rdata_q <= t2h_q;
                default:                   rdata_q <= `REG_RESET;
            endcase
        end
    end

    assign sfr_rdata = rdata_q;

    // ======================================================================
    // Checks
    a_gate_blocks_count: assert property (@(posedge clk) disable iff (srst)
        (mode_q[`MODE_FIRST_GATE] && gate_input != first_gate_polarity && !wr_hit(`FIRST_TIMER_LOW_ADDR))
        |=> $stable(tl0_q))
        else $error("first timer counted while gated off");
    a_timer_clock_control_top_zero: assert property (@(posedge clk) disable iff (srst)
        (sfr_rd && sfr_addr == `TIMER_CLOCK_CONTROL_ADDR) |=> sfr_rdata[7:6] == 2'b00)
        else $error("clock control top bits not zero");
    a_div12_spacing: assert property (@(posedge clk) disable iff (srst)
        tick12 |=> !tick12 [*8])
        else $error("divide by 12 tick too early");
    a_mode2_reload: assert property (@(posedge clk) disable iff (srst)
        (m0 == general_timer_pkg::MODE_8BIT_RELOAD && en0 && tick0 && tl0_q == `BYTE_ALL_ONES
         && !wr_hit(`FIRST_TIMER_LOW_ADDR) && !wr_hit(`FIRST_TIMER_HIGH_ADDR)) |=> (tl0_q == th0_q) && tf0_q)
        else $error("8-bit reload missed");
    a_inactive_holds: assert property (@(posedge clk) disable iff (srst)
        (m1 == general_timer_pkg::MODE_SPLIT && !wr_hit(`SECOND_TIMER_LOW_ADDR)) |=> $stable(tl1_q))
        else $error("inactive second timer moved");
    a_wrap16_reload: assert property (@(posedge clk) disable iff (srst)
        (wrap16 && !capture && !sfr_wr) |=> ({t2h_q, t2l_q} == {rlh_q, rll_q}) && third_timer_high_overflow_flag_q)
        else $error("16-bit reload missed");
    a_low_free_run: assert property (@(posedge clk) disable iff (srst)
        (split_q && tick2l && t2l_q != `BYTE_ALL_ONES && !wr_hit(`THIRD_COUNT_LOW_ADDR))
        |=> t2l_q == $past(t2l_q) + 8'h01)
        else $error("split low byte did not count");
    a_flag_sticky: assert property (@(posedge clk) disable iff (srst)
        (third_timer_high_overflow_flag_q && !wr_hit(`THIRD_TIMER_CONTROL_ADDR)) |=> third_timer_high_overflow_flag_q)
        else $error("high flag cleared by hardware");
    a_capture_copy: assert property (@(posedge clk) disable iff (srst)
        capture |=> ({rlh_q, rll_q} == $past({t2h_q, t2l_q})) && third_timer_high_overflow_flag_q)
        else $error("capture did not copy count");
    a_low_irq_gate: assert property (@(posedge clk) disable iff (srst)
        (wrap_l && len_q && !wr_hit(`THIRD_TIMER_CONTROL_ADDR)) |=> third_timer_irq)
        else $error("low wrap interrupt missing");

endmodule

/* tb/timer_pins_model.sv */
// Purpose: Far-side count pin and divided oscillator of the timer group.
// Assumes: The pin changes just after rising clk edges.
// Notes:   The pin idles high, so each pulse gives one falling edge.
`timescale 1ns/1ps
module timer_pins_model
(
    input  wire logic clk,
    output logic      pin = 1'b1,
    output logic      ext = 1'b1
);
    // ==========================================
    // Pulse driver
    // Four-cycle phases outlast the three-cycle pin synchroniser.
    task automatic pulse(input int n);
        repeat (n)
        begin
            @(posedge clk) pin <= 1'b0;
            repeat (4) @(posedge clk);
            pin <= 1'b1;
            repeat (4) @(posedge clk);
        end
    endtask
    // The oscillator stands still between calls; seven-cycle phases let the synchroniser see each edge.
    task automatic osc(input int n);
        repeat (n)
        begin
            @(posedge clk) ext <= 1'b0;
            repeat (7) @(posedge clk);
            ext <= 1'b1;
            repeat (7) @(posedge clk);
        end
    endtask
endmodule

/* tb/general_timer_group_tb.sv */
// Purpose: Self-checking bench of the timer group.
// Assumes: Read data is valid one cycle after the read strobe.
// Notes:   Gate input is low except while the gated count is being measured.
`timescale 1ns/1ps
`include "general_timer_regs.svh"
module general_timer_group_tb;
    logic       clk = 1'b0;
    logic       srst = 1'b1;
    logic [7:0] a = 8'h00;
    logic [7:0] d = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       g = 1'b0;
    wire        xc;
    logic [7:0] q;
    wire        cp0;
    wire  [2:0] f;
    int         n_fail = 0;
    int         checked = 0;
    always #2.5 clk = ~clk;
    // ==========================================
    // Block and far side
    general_timer_group dut_u (.clk(clk), .srst(srst), .sfr_addr(a), .sfr_wr(wr), .sfr_rd(rd),
        .sfr_wdata(d), .sfr_rdata(q), .gate_input(g), .first_gate_polarity(1'b1),
        .second_gate_polarity(1'b1), .first_count_pin(cp0), .second_count_pin(1'b1),
        .ext_clk_div8(xc), .first_timer_overflow_flag(f[0]), .second_timer_overflow_flag(f[1]),
        .third_timer_irq(f[2]));
    timer_pins_model pins_u (.clk(clk), .pin(cp0), .ext(xc));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic w(input logic [7:0] ad, input logic [7:0] v);
        @(posedge clk);
        a <= ad;
        d <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic r(input logic [7:0] ad, input logic [7:0] e);
        @(posedge clk);
        a <= ad;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(q, e);
    endtask
    task automatic wait_f(input int s);
        repeat (300)
            if (f[s] !== 1'b1)
                @(negedge clk);
        chk({7'h00, f[s]}, 8'h01);
    endtask
    task automatic t0(input logic [7:0] m, input logic [7:0] lo, input logic [7:0] hi);
        w(`CLASSIC_TIMER_MODE_ADDR, m);
        w(`FIRST_TIMER_LOW_ADDR, lo);
        w(`FIRST_TIMER_HIGH_ADDR, hi);
        w(`TIMER_CONTROL_ADDR, 8'h10);
    endtask
    task automatic t_regs();
        r(`TIMER_CLOCK_CONTROL_ADDR, 8'h00);
        w(`TIMER_CLOCK_CONTROL_ADDR, 8'h3F);
        r(`TIMER_CLOCK_CONTROL_ADDR, 8'h3F);
        w(`TIMER_CLOCK_CONTROL_ADDR, 8'h14);
    endtask
    task automatic t_wrap();
        t0(8'h00, 8'hFE, 8'hFF);
        wait_f(0);
        w(`TIMER_CONTROL_ADDR, 8'h00);
        r(`FIRST_TIMER_HIGH_ADDR, 8'h00);
        t0(8'h01, 8'hF0, 8'hFF);
        wait_f(0);
        w(`TIMER_CONTROL_ADDR, 8'h00);
        r(`FIRST_TIMER_HIGH_ADDR, 8'h00);
        t0(8'h02, 8'hFE, 8'hF0);
        wait_f(0);
        w(`TIMER_CONTROL_ADDR, 8'h00);
        r(`FIRST_TIMER_HIGH_ADDR, 8'hF0);
    endtask
    task automatic t_pins();
        t0(8'h09, 8'h00, 8'h00);
        repeat (20) @(posedge clk);
        r(`FIRST_TIMER_LOW_ADDR, 8'h00);
        @(posedge clk) g <= 1'b1;
        repeat (5) @(posedge clk);
        g <= 1'b0;
        r(`FIRST_TIMER_LOW_ADDR, 8'h05);
        t0(8'h05, 8'h00, 8'h00);
        pins_u.pulse(3);
        r(`FIRST_TIMER_LOW_ADDR, 8'h03);
        w(`TIMER_CONTROL_ADDR, 8'h00);
    endtask
    task automatic t_third();
        w(`THIRD_RELOAD_LOW_ADDR, 8'h34);
        w(`THIRD_RELOAD_HIGH_ADDR, 8'h12);
        w(`THIRD_COUNT_LOW_ADDR, 8'hF0);
        w(`THIRD_COUNT_HIGH_ADDR, 8'hFF);
        w(`THIRD_TIMER_CONTROL_ADDR, 8'h04);
        wait_f(2);
        w(`THIRD_TIMER_CONTROL_ADDR, 8'h28);
        wait_f(2);
        r(`THIRD_COUNT_HIGH_ADDR, 8'h12);
    endtask
    task automatic t_split();
        t0(8'h33, 8'h00, 8'hF8);
        w(`TIMER_CONTROL_ADDR, 8'h40);
        wait_f(1);
        w(`TIMER_CONTROL_ADDR, 8'h00);
        r(`FIRST_TIMER_LOW_ADDR, 8'h02);
        r(`SECOND_TIMER_LOW_ADDR, 8'h00);
    endtask
    task automatic t_capture();
        w(`THIRD_TIMER_CONTROL_ADDR, 8'h10);
        w(`THIRD_COUNT_LOW_ADDR, 8'hA5);
        w(`THIRD_COUNT_HIGH_ADDR, 8'h5A);
        pins_u.osc(1);
        r(`THIRD_RELOAD_LOW_ADDR, 8'hA5);
        r(`THIRD_RELOAD_HIGH_ADDR, 8'h5A);
        wait_f(2);
    endtask
    task automatic finish_test();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_wrap();
        t_split();
        t_pins();
        t_third();
        t_capture();
        finish_test();
    end
    initial
    begin
        #50000;
        n_fail++;
        finish_test();
    end
endmodule
